// >>> logic/thermal_supervisor.sv
// Thermal replica, ambient correction, start hold, lockout and probe supervision.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module thermal_supervisor import thermal_pkg::*; #(
    parameter int NUM_PROBES = NUM_PROBES_DEF,
    parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
    input  wire logic                        CORE_CLK,
    input  wire logic                        RST,
    input  wire logic [5:0]                  AVS_ADDRESS,
    input  wire logic                        AVS_READ,
    input  wire logic                        AVS_WRITE,
    input  wire logic [31:0]                 AVS_WRITEDATA,
    input  wire logic [3:0]                  AVS_BYTEENABLE,
    output logic      [31:0]                 AVS_READDATA,
    output logic                             AVS_WAITREQUEST,
    input  wire logic [15:0]                 IEQ_SQ,
    input  wire logic                        MOTOR_STARTING,
    input  wire logic [NUM_PROBES*TEMP_W-1:0] PROBE_TEMP,
    input  wire logic [NUM_PROBES*RES_W-1:0]  PROBE_RES,
    output logic                             THERM_ALARM,
    output logic                             THERM_TRIP,
    output logic                             LOCKOUT_OPEN,
    output logic      [NUM_PROBES-1:0]       PROBE_ALARM,
    output logic      [NUM_PROBES-1:0]       PROBE_TRIP,
    output logic      [NUM_PROBES-1:0]       PROBE_FAIL
);
    localparam int SW = $clog2(SEC_CYCLES + 1);

    if (NUM_PROBES < 2 || NUM_PROBES > 16) begin : g_bad_probes
        $error("NUM_PROBES must lie between 2 and 16.");
    end
    if (SEC_CYCLES < 1) begin : g_bad_sec
        $error("SEC_CYCLES must be at least 1.");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic logic in_bank(input logic [5:0] a, input logic [5:0] base, int n);
        in_bank = a >= base && 32'(a - base) < n;
    endfunction

    // Bus slave: every request sees exactly one wait cycle.
    logic        wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        req, acc;
    logic [3:0]  ch_idx;
    assign req    = AVS_READ || AVS_WRITE;
    assign acc    = req && !wait_reg;
    assign ch_idx = AVS_ADDRESS[3:0];

    // Software registers.
    logic [31:0] ctrl_reg, ctrl_next, levels_reg, levels_next, tconst_reg, tconst_next;
    logic [31:0] reslim_reg, reslim_next, recip_reg, recip_next;
    logic [31:0] chcfg_reg [NUM_PROBES];
    logic [31:0] chcfg_next [NUM_PROBES];
    logic [31:0] lv_w;
    logic [6:0]  alarm_lvl, lock_lvl, trip_lvl;
    assign alarm_lvl = levels_reg[6:0];
    assign lock_lvl  = levels_reg[14:8];
    assign trip_lvl  = levels_reg[22:16];

    // Thermal state and outputs.
    logic [SW-1:0]        sec_reg, sec_next;
    logic                 tick_reg, tick_next;
    logic [THETA_W-1:0]   theta_reg, theta_next;
    logic [6:0]           coef_reg, coef_next;
    logic                 hold_reg, hold_next;
    logic                 alarm_reg, alarm_next, trip_reg, trip_next, lock_reg, lock_next;
    logic [33:0]          prod;
    logic [THETA_W-1:0]   target;
    logic [4:0]           tau;
    logic signed [THETA_W:0] diff;
    logic                 rising;

    // Probe side.
    logic signed [TEMP_W-1:0] temp_c [NUM_PROBES];
    logic [NUM_PROBES-1:0]    fail_w, alarm_w, trip_w;
    logic [3:0]               main_idx, back_idx, src_idx;
    logic signed [TEMP_W-1:0] amb_temp;

    probe_if pif [NUM_PROBES] ();

    for (genvar g = 0; g < NUM_PROBES; g++) begin : g_ch
        logic signed [TEMP_W-1:0] raw;
        assign raw = PROBE_TEMP[g*TEMP_W +: TEMP_W];
        assign temp_c[g] = raw < TEMP_MIN ? TEMP_MIN : (raw > TEMP_MAX ? TEMP_MAX : raw);
        assign pif[g].temp      = temp_c[g];
        assign pif[g].res       = PROBE_RES[g*RES_W +: RES_W];
        assign pif[g].res_min   = reslim_reg[15:0];
        assign pif[g].res_max   = reslim_reg[31:16];
        assign pif[g].alarm_thr = chcfg_reg[g][8:0];
        assign pif[g].alarm_dly = chcfg_reg[g][15:9];
        assign pif[g].trip_thr  = chcfg_reg[g][24:16];
        assign pif[g].trip_dly  = chcfg_reg[g][31:25];
        assign pif[g].tick      = tick_reg;
        assign fail_w[g]  = pif[g].fail;
        assign alarm_w[g] = pif[g].alarm;
        assign trip_w[g]  = pif[g].trip;
        probe_channel u_ch (
            .CORE_CLK (CORE_CLK),
            .RST      (RST),
            .p        (pif[g])
        );
    end

    assign PROBE_ALARM = alarm_w;
    assign PROBE_TRIP  = trip_w;
    assign PROBE_FAIL  = fail_w;

    // Ambient source selection and correction coefficient.
    always_comb begin
        main_idx = 32'(ctrl_reg[11:8]) < NUM_PROBES ? ctrl_reg[11:8] : 4'h0;
        back_idx = 32'(ctrl_reg[15:12]) < NUM_PROBES ? ctrl_reg[15:12] : 4'h0;
        src_idx  = fail_w[main_idx] ? back_idx : main_idx;
        amb_temp = temp_c[src_idx];
        coef_next = ctrl_reg[1] ? amb_coef(amb_temp) : COEF_UNITY;
    end

    // Register file and bus answer.
    always_comb begin
        ctrl_next   = ctrl_reg;
        levels_next = levels_reg;
        tconst_next = tconst_reg;
        reslim_next = reslim_reg;
        recip_next  = recip_reg;
        chcfg_next  = chcfg_reg;
        rdata_next  = rdata_reg;
        wait_next   = !(req && wait_reg);
        lv_w        = merge(levels_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        if (acc && AVS_WRITE) begin
            case (AVS_ADDRESS)
                REG_CTRL:      ctrl_next = merge(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
                REG_LEVELS: begin
                    levels_next = lv_w & 32'h007f_7f7f;
                    if (lv_w[6:0] < LEVEL_MIN) levels_next[6:0] = LEVEL_MIN;
                    if (lv_w[6:0] > LEVEL_MAX) levels_next[6:0] = LEVEL_MAX;
                    if (lv_w[14:8] < LEVEL_MIN) levels_next[14:8] = LEVEL_MIN;
                end
                REG_TCONST:    tconst_next = merge(tconst_reg, AVS_WRITEDATA, AVS_BYTEENABLE) &
                                             32'h001f_1f1f;
                REG_RES_LIM:   reslim_next = merge(reslim_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
                REG_ITH_RECIP: recip_next = merge(recip_reg, AVS_WRITEDATA, AVS_BYTEENABLE) &
                                            32'h0000_ffff;
                default: begin
                    if (in_bank(AVS_ADDRESS, REG_CH_CFG, NUM_PROBES)) begin
                        chcfg_next[ch_idx] = merge(chcfg_reg[ch_idx], AVS_WRITEDATA,
                                                   AVS_BYTEENABLE);
                    end
                end
            endcase
        end
        if (req && wait_reg) begin
            case (AVS_ADDRESS)
                REG_CTRL:      rdata_next = ctrl_reg;
                REG_LEVELS:    rdata_next = levels_reg;
                REG_TCONST:    rdata_next = tconst_reg;
                REG_RES_LIM:   rdata_next = reslim_reg;
                REG_ITH_RECIP: rdata_next = recip_reg;
                REG_STATUS:    rdata_next = {1'b0, coef_reg, hold_reg, lock_reg, trip_reg,
                                             alarm_reg, 2'b00, theta_reg};
                default: begin
                    rdata_next = 32'h0000_0000;
                    if (in_bank(AVS_ADDRESS, REG_CH_CFG, NUM_PROBES)) begin
                        rdata_next = chcfg_reg[ch_idx];
                    end else if (in_bank(AVS_ADDRESS, REG_CH_STAT, NUM_PROBES)) begin
                        rdata_next = {13'h0000, fail_w[ch_idx], trip_w[ch_idx],
                                      alarm_w[ch_idx], 6'h00, temp_c[ch_idx]};
                    end
                end
            endcase
        end
    end

    // Thermal replica, start hold and thermal outputs.
    always_comb begin
        sec_next  = sec_reg == SW'(SEC_CYCLES - 1) ? '0 : sec_reg + 1'b1;
        tick_next = sec_reg == SW'(SEC_CYCLES - 1);
        prod      = 34'(IEQ_SQ) * 34'(recip_reg[15:0]);
        target    = |prod[33:THETA_W+RECIP_SHIFT] ? '1 :
                    prod[THETA_W+RECIP_SHIFT-1:RECIP_SHIFT];
        if (IEQ_SQ == 16'h0000) tau = tconst_reg[20:16];
        else if (target > HIGH_LOAD) tau = tconst_reg[12:8];
        else tau = tconst_reg[4:0];
        diff   = $signed({1'b0, target}) - $signed({1'b0, theta_reg});
        rising = !diff[THETA_W];
        hold_next = ctrl_reg[0] && MOTOR_STARTING &&
                    (hold_reg || reached(theta_reg, HOLD_PCT, coef_reg));
        theta_next = theta_reg;
        if (tick_reg && !(hold_reg && rising)) begin
            theta_next = THETA_W'($signed({1'b0, theta_reg}) + (diff >>> tau));
            if (diff != 0 && (diff >>> tau) == 0) begin
                theta_next = rising ? theta_reg + 1'b1 : theta_reg - 1'b1;
            end
        end
        alarm_next = reached(theta_reg, alarm_lvl, coef_reg);
        trip_next  = reached(theta_reg, trip_lvl, coef_reg);
        lock_next  = reached(theta_reg, lock_lvl, coef_reg);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h0000_0000;
            ctrl_reg   <= CTRL_RST;
            levels_reg <= LEVELS_RST;
            tconst_reg <= TCONST_RST;
            reslim_reg <= RES_LIM_RST;
            recip_reg  <= ITH_RECIP_RST;
            for (int i = 0; i < NUM_PROBES; i++) chcfg_reg[i] <= CH_CFG_RST;
            sec_reg    <= '0;
            tick_reg   <= 1'b0;
            theta_reg  <= '0;
            coef_reg   <= COEF_UNITY;
            hold_reg   <= 1'b0;
            alarm_reg  <= 1'b0;
            trip_reg   <= 1'b0;
            lock_reg   <= 1'b0;
        end else begin
            wait_reg   <= wait_next;
            rdata_reg  <= rdata_next;
            ctrl_reg   <= ctrl_next;
            levels_reg <= levels_next;
            tconst_reg <= tconst_next;
            reslim_reg <= reslim_next;
            recip_reg  <= recip_next;
            chcfg_reg  <= chcfg_next;
            sec_reg    <= sec_next;
            tick_reg   <= tick_next;
            theta_reg  <= theta_next;
            coef_reg   <= coef_next;
            hold_reg   <= hold_next;
            alarm_reg  <= alarm_next;
            trip_reg   <= trip_next;
            lock_reg   <= lock_next;
        end
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign THERM_ALARM     = alarm_reg;
    assign THERM_TRIP      = trip_reg;
    assign LOCKOUT_OPEN    = lock_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence bus_req_s;
        req && wait_reg;
    endsequence
    sequence bus_done_s;
        !wait_reg ##1 wait_reg;
    endsequence
    sequence heat_step_s;
        tick_reg && !hold_reg && target > theta_reg;
    endsequence

    bus_answer_a: assert property (bus_req_s |=> bus_done_s)
        else $error("Bus request not answered after one wait cycle.");
    trip_level_a: assert property (reached(theta_reg, trip_lvl, coef_reg) |=> THERM_TRIP)
        else $error("Thermal trip missing at trip level.");
    alarm_level_a: assert property (alarm_reg == reached($past(theta_reg),
                                    $past(alarm_lvl), $past(coef_reg)))
        else $error("Thermal alarm disagrees with alarm level.");
    lockout_close_a: assert property (!reached(theta_reg, lock_lvl, coef_reg) |=>
                                      !LOCKOUT_OPEN)
        else $error("Lockout contact open below lockout level.");
    hold_freeze_a: assert property (hold_reg && tick_reg && target > theta_reg |=>
                                    $stable(theta_reg))
        else $error("Thermal state rose during start hold.");
    hold_release_a: assert property (!MOTOR_STARTING |=> !hold_reg)
        else $error("Start hold kept after starting ended.");
    coef_cool_a: assert property (ctrl_reg[1] && amb_temp < 10'sd45 |=>
                                  coef_reg == COEF_UNITY)
        else $error("Coefficient not unity below first table point.");
    coef_hot_a: assert property (ctrl_reg[1] && amb_temp >= 10'sd65 |=>
                                 coef_reg == 7'd75)
        else $error("Coefficient not 0.75 at or above last table point.");
    backup_source_a: assert property (fail_w[main_idx] |-> src_idx == back_idx)
        else $error("Ambient not taken from back-up probe on main failure.");
    lock_min_a: assert property (lock_lvl >= LEVEL_MIN)
        else $error("Lockout level below minimum.");
    lock_open_a: assert property (reached(theta_reg, lock_lvl, coef_reg) |=> LOCKOUT_OPEN)
        else $error("Lockout contact closed at lockout level.");
    trip_clear_a: assert property (!reached(theta_reg, trip_lvl, coef_reg) |=> !THERM_TRIP)
        else $error("Thermal trip stands below trip level.");
    heat_step_a: assert property (heat_step_s |=> theta_reg > $past(theta_reg))
        else $error("Thermal state did not rise toward a higher target.");
    cool_step_a: assert property (tick_reg && IEQ_SQ == 16'h0000 && theta_reg != '0 |=>
                                  theta_reg < $past(theta_reg))
        else $error("Thermal state did not cool at zero current.");
    alarm_range_a: assert property (alarm_lvl >= LEVEL_MIN && alarm_lvl <= LEVEL_MAX)
        else $error("Thermal alarm level outside its range.");
    coef_off_a: assert property (!ctrl_reg[1] |=> coef_reg == COEF_UNITY)
        else $error("Coefficient not unity with ambient correction off.");
    src_main_a: assert property (!fail_w[main_idx] |-> src_idx == main_idx)
        else $error("Ambient not taken from main probe while it is healthy.");
endmodule

// >>> include/thermal_pkg.sv
// Constants, register map and shared functions of the motor thermal supervisor.
package thermal_pkg;
    localparam int NUM_PROBES_DEF = 10;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SECOND_NS      = 1000000000;
    localparam int SEC_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
    localparam int TEMP_W  = 10;
    localparam int RES_W   = 16;
    localparam int THR_W   = 9;
    localparam int DLY_W   = 7;
    localparam int THETA_W = 18;
    localparam logic [5:0] REG_CTRL      = 6'h00;
    localparam logic [5:0] REG_LEVELS    = 6'h01;
    localparam logic [5:0] REG_TCONST    = 6'h02;
    localparam logic [5:0] REG_STATUS    = 6'h03;
    localparam logic [5:0] REG_RES_LIM   = 6'h04;
    localparam logic [5:0] REG_ITH_RECIP = 6'h05;
    localparam logic [5:0] REG_CH_CFG    = 6'h10;
    localparam logic [5:0] REG_CH_STAT   = 6'h20;
    localparam logic [31:0] CTRL_RST      = 32'h0000_1000;
    localparam logic [31:0] LEVELS_RST    = 32'h0064_145a;
    localparam logic [31:0] TCONST_RST    = 32'h000c_0a0a;
    localparam logic [31:0] RES_LIM_RST   = 32'hf000_0100;
    localparam logic [31:0] ITH_RECIP_RST = 32'h0000_0100;
    localparam logic [31:0] CH_CFG_RST    = 32'h0a64_0a50;
    localparam logic signed [TEMP_W-1:0] TEMP_MIN = -10'sd40;
    localparam logic signed [TEMP_W-1:0] TEMP_MAX = 10'sd400;
    localparam logic [6:0] COEF_UNITY = 7'd100;
    localparam logic [6:0] HOLD_PCT   = 7'd90;
    localparam logic [6:0] LEVEL_MIN  = 7'd20;
    localparam logic [6:0] LEVEL_MAX  = 7'd100;
    localparam logic [THETA_W-1:0] HIGH_LOAD = 18'h19000;
    localparam int RECIP_SHIFT = 8;
    localparam int PCT_SHIFT   = 8;

    function automatic logic [6:0] amb_coef(input logic signed [TEMP_W-1:0] t);
        if (t < 10'sd45) amb_coef = COEF_UNITY;
        else if (t < 10'sd50) amb_coef = 7'd95;
        else if (t < 10'sd55) amb_coef = 7'd90;
        else if (t < 10'sd60) amb_coef = 7'd85;
        else if (t < 10'sd65) amb_coef = 7'd80;
        else amb_coef = 7'd75;
    endfunction

    function automatic logic reached(input logic [THETA_W-1:0] th, input logic [6:0] pct,
                                     input logic [6:0] coef);
        logic [25:0] lhs;
        logic [25:0] rhs;
        lhs = 26'(th) * 26'(COEF_UNITY);
        rhs = (26'(pct) * 26'(coef)) << PCT_SHIFT;
        reached = lhs >= rhs;
    endfunction
endpackage

// >>> include/probe_if.sv
// Connection between the supervisor and one probe channel.
`timescale 1ns/1ps
interface probe_if;
    import thermal_pkg::*;
    logic signed [TEMP_W-1:0] temp;
    logic        [RES_W-1:0]  res;
    logic        [RES_W-1:0]  res_min;
    logic        [RES_W-1:0]  res_max;
    logic        [THR_W-1:0]  alarm_thr;
    logic        [THR_W-1:0]  trip_thr;
    logic        [DLY_W-1:0]  alarm_dly;
    logic        [DLY_W-1:0]  trip_dly;
    logic                     tick;
    logic                     alarm;
    logic                     trip;
    logic                     fail;
    modport sup (output temp, res, res_min, res_max, alarm_thr, trip_thr, alarm_dly,
                 trip_dly, tick, input alarm, trip, fail);
    modport chan (input temp, res, res_min, res_max, alarm_thr, trip_thr, alarm_dly,
                  trip_dly, tick, output alarm, trip, fail);
endinterface

// >>> logic/probe_channel.sv
// One probe channel: delayed alarm and trip, and resistance range check.
`timescale 1ns/1ps
module probe_channel import thermal_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic RST,
    probe_if.chan    p
);
    logic [DLY_W:0]   acnt_reg, acnt_next, tcnt_reg, tcnt_next;
    logic             alarm_reg, alarm_next, trip_reg, trip_next, fail_reg, fail_next;
    logic             a_above, t_above;

    assign a_above = p.temp > $signed({1'b0, p.alarm_thr});
    assign t_above = p.temp > $signed({1'b0, p.trip_thr});

    always_comb begin
        acnt_next = a_above ? acnt_reg : '0;
        tcnt_next = t_above ? tcnt_reg : '0;
        if (a_above && p.tick && acnt_reg != '1) acnt_next = acnt_reg + 1'b1;
        if (t_above && p.tick && tcnt_reg != '1) tcnt_next = tcnt_reg + 1'b1;
        alarm_next = a_above && (p.alarm_dly == '0 || acnt_reg > {1'b0, p.alarm_dly});
        trip_next  = t_above && (p.trip_dly == '0 || tcnt_reg > {1'b0, p.trip_dly});
        fail_next  = p.res < p.res_min || p.res > p.res_max;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            acnt_reg  <= '0;
            tcnt_reg  <= '0;
            alarm_reg <= 1'b0;
            trip_reg  <= 1'b0;
            fail_reg  <= 1'b0;
        end else begin
            acnt_reg  <= acnt_next;
            tcnt_reg  <= tcnt_next;
            alarm_reg <= alarm_next;
            trip_reg  <= trip_next;
            fail_reg  <= fail_next;
        end
    end

    assign p.alarm = alarm_reg;
    assign p.trip  = trip_reg;
    assign p.fail  = fail_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    below_clear_a: assert property (!t_above |=> !trip_reg)
        else $error("Probe trip stands while temperature is below threshold.");
    fail_range_a: assert property (p.res > p.res_max |=> fail_reg)
        else $error("Probe failure not raised for resistance above range.");
endmodule

// >>> test/probe_motor_model.sv
// Probe inputs and motor starting circuit facing the supervisor.
`timescale 1ns/1ps
module probe_motor_model import thermal_pkg::*; #(
    parameter int NUM_PROBES = NUM_PROBES_DEF
) (
    input  wire logic                         clk,
    input  wire logic                         start_req,
    input  wire logic                         lockout_open,
    input  wire logic [NUM_PROBES*TEMP_W-1:0] temp_set,
    input  wire logic [NUM_PROBES*RES_W-1:0]  res_set,
    output logic                              starting,
    output logic      [NUM_PROBES*TEMP_W-1:0] temp,
    output logic      [NUM_PROBES*RES_W-1:0]  res
);
    logic starting_reg = 1'b0;
    logic starting_next;
    always_comb begin
        starting_next = starting_reg;
        if (!start_req) begin
            starting_next = 1'b0;
        end else if (!lockout_open) begin
            starting_next = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        starting_reg <= starting_next;
    end
    assign starting = starting_reg;
    assign temp     = temp_set;
    assign res      = res_set;
endmodule

// >>> test/motor_thermal_supervision_tb.sv
// Self-checking bench for the motor thermal supervisor.
`timescale 1ns/1ps
module motor_thermal_supervision_tb;
    import thermal_pkg::*;
    localparam int NP = 10;
    logic                 clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, start_req = 1'b0;
    logic                 starting, wait_req, alarm, trip, lock;
    logic [5:0]           addr = '0;
    logic [31:0]          wdata = '0, rdata, q, seed = 32'ha0ed2685;
    logic [15:0]          ieq = '0;
    logic [NP-1:0]        p_alarm, p_trip, p_fail;
    logic [NP*TEMP_W-1:0] temp_set = {NP{10'sd20}}, temp;
    logic [NP*RES_W-1:0]  res_set = {NP{16'h1000}}, res;
    int                   mismatches = 0, n_checks = 0;
    initial forever #25 clk = ~clk;
    thermal_supervisor #(.NUM_PROBES(NP), .SEC_CYCLES(10)) dut (.CORE_CLK(clk), .RST(rst),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .IEQ_SQ(ieq), .MOTOR_STARTING(starting), .PROBE_TEMP(temp), .PROBE_RES(res),
        .THERM_ALARM(alarm), .THERM_TRIP(trip), .LOCKOUT_OPEN(lock),
        .PROBE_ALARM(p_alarm), .PROBE_TRIP(p_trip), .PROBE_FAIL(p_fail));
    probe_motor_model #(.NUM_PROBES(NP)) model (.clk(clk), .start_req(start_req),
        .lockout_open(lock), .temp_set(temp_set), .res_set(res_set),
        .starting(starting), .temp(temp), .res(res));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) bad($sformatf("word %h exp %h", g, e));
    endtask
    task automatic chk_pins(input logic [NP-1:0] g, input logic [NP-1:0] e);
        n_checks++;
        if (g !== e) bad($sformatf("pins %b exp %b", g, e));
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            bad("bus hang");
            give_verdict();
        end
    endtask
    task automatic tick(input int n);
        repeat (n * 10) @(posedge clk);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] coef_of(input int t);
        return t < 45 ? 7'd100 : t >= 65 ? 7'd75 : 7'(100 - (t - 40) / 5 * 5);
    endfunction
    function automatic logic [2:0] flags(input int p, input int c);
        return {p * 100 >= 20 * c, p * 100 >= 100 * c, p * 100 >= 90 * c};
    endfunction
    initial begin
        logic [5:0]  ra [8] = '{REG_CTRL, REG_LEVELS, REG_TCONST, REG_RES_LIM,
                                REG_ITH_RECIP, REG_CH_CFG, REG_CH_CFG + 6'd9, REG_STATUS};
        logic [31:0] re [8] = '{CTRL_RST, LEVELS_RST, TCONST_RST, RES_LIM_RST,
                                ITH_RECIP_RST, CH_CFG_RST, CH_CFG_RST, 32'h6400_0000};
        logic [15:0] cor [4] = '{16'h00ff, 16'h0100, 16'hf000, 16'hf001};
        int          t_amb [6] = '{30, 47, 52, 58, 61, 70};
        int          pcts [3] = '{50, 95, 112};
        logic [15:0] r16;
        logic [NP-1:0] ef;
        logic [17:0] th0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ra[i], '0);
            chk_word(q, re[i]);
        end
        bus(1'b1, 6'h3f, 32'hffff_ffff);
        bus(1'b0, 6'h3f, '0);
        chk_word(q, '0);
        for (int k = 0; k < 6; k++) begin
            for (int g = 0; g < NP; g++) begin
                seed = lfsr(seed);
                r16 = seed[31] ? seed[15:0] : {seed[15] ? 8'hf0 : 8'h00, seed[7:0]};
                if (k == 0 && g < 4) r16 = cor[g];
                res_set[g*RES_W +: RES_W] <= r16;
                ef[g] = r16 < 16'h0100 || r16 > 16'hf000;
            end
            temp_set[k*TEMP_W +: TEMP_W] <= 10'(seed[21:16]);
            repeat (3) @(posedge clk);
            chk_pins(p_fail, ef);
            bus(1'b0, REG_CH_STAT + 6'(k), '0);
            chk_word(q, {13'h0, ef[k], 8'h0, 4'h0, seed[21:16]});
        end
        res_set <= {NP{16'h1000}};
        temp_set[3*TEMP_W +: 2*TEMP_W] <= {10'sd450, -10'sd100};
        repeat (2) @(posedge clk);
        bus(1'b0, REG_CH_STAT + 6'd3, '0);
        chk_word(q, {22'h0, -10'sd40});
        bus(1'b0, REG_CH_STAT + 6'd4, '0);
        chk_word(q, {22'h0, 10'sd400});
        temp_set[3*TEMP_W +: 2*TEMP_W] <= {2{10'sd20}};
        bus(1'b1, REG_CH_CFG + 6'd2, {7'd2, 9'd60, 7'd0, 9'd50});
        temp_set[2*TEMP_W +: TEMP_W] <= 10'sd55;
        repeat (4) @(posedge clk);
        chk_pins({p_trip[2], p_alarm[2]}, 2'b01);
        temp_set[2*TEMP_W +: TEMP_W] <= 10'sd65;
        repeat (4) @(posedge clk);
        chk_pins({p_trip[2], p_alarm[2]}, 2'b01);
        tick(1);
        chk_pins({p_trip[2], p_alarm[2]}, 2'b01);
        tick(4);
        chk_pins({p_trip[2], p_alarm[2]}, 2'b11);
        temp_set[2*TEMP_W +: TEMP_W] <= 10'sd20;
        repeat (4) @(posedge clk);
        chk_pins({p_trip[2], p_alarm[2]}, 2'b00);
        bus(1'b1, REG_TCONST, 32'h0);
        for (int i = 0; i < 3; i++) begin
            ieq <= 16'(pcts[i] * 256);
            tick(3);
            chk_pins({lock, trip, alarm}, flags(pcts[i], 100));
        end
        ieq <= 16'(80 * 256);
        bus(1'b1, REG_CTRL, 32'h0000_1002);
        for (int i = 0; i < 6; i++) begin
            temp_set[0 +: TEMP_W] <= 10'(t_amb[i]);
            tick(3);
            bus(1'b0, REG_STATUS, '0);
            chk_word(q[30:24], coef_of(t_amb[i]));
            chk_pins({lock, trip, alarm}, flags(80, coef_of(t_amb[i])));
        end
        res_set[0 +: RES_W] <= 16'h0000;
        temp_set[TEMP_W +: TEMP_W] <= 10'sd40;
        tick(1);
        bus(1'b0, REG_STATUS, '0);
        chk_word(q[30:24], 32'd100);
        ieq <= '0;
        tick(3);
        chk_pins({lock, trip, alarm}, 3'b000);
        res_set[0 +: RES_W] <= 16'h1000;
        temp_set[0 +: TEMP_W] <= 10'sd20;
        bus(1'b1, REG_TCONST, 32'h0000_0303);
        bus(1'b1, REG_CTRL, 32'h0000_1003);
        start_req <= 1'b1;
        repeat (3) @(posedge clk);
        ieq <= 16'(112 * 256);
        tick(30);
        bus(1'b0, REG_STATUS, '0);
        chk_word(q[23:20], 4'b1101);
        start_req <= 1'b0;
        tick(30);
        chk_pins({lock, trip, alarm}, 3'b111);
        bus(1'b1, REG_TCONST, 32'h0000_1f00);
        bus(1'b1, REG_ITH_RECIP, 32'h0000_0400);
        bus(1'b0, REG_STATUS, '0);
        th0 = q[17:0];
        tick(3);
        bus(1'b0, REG_STATUS, '0);
        chk_pins(q[17:0] > th0 && q[17:0] - th0 <= 18'd4, 1'b1);
        give_verdict();
    end
endmodule
